/* File: src/cpt_top.sv */
// Top: CPU priority level, latency select and trap status over AHB-Lite
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module cpt_top (
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic CE_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire cpt_pkg::cpt_evt_t TRAP_EVT_I,
   input wire logic PRIO_LOAD_I,
   input wire logic [3:0] PRIO_LEVEL_I,
   output cpt_pkg::cpt_core_t CORE_O,
   output logic IRQ_O
);
   import cpt_pkg::*;

   default clocking chk_cb @(posedge CLK_I);
   endclocking
   default disable iff (RESET_I);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [2:0] prio_low_reg;
   logic prio_top_reg;
   logic var_lat_reg;
   logic nesting_disable_reg;
   logic nvm_flag_reg;
   logic loop_flag_reg;
   logic pll_flag_reg;
   logic sw_hard_flag_reg;
   logic [3:0] irq_stat_reg;
   logic [3:0] irq_mask_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_reg;
   logic [3:0] evt;

   // ----------------------------------------------------------------------
   // Bus slave: single-cycle, zero wait, always OKAY
   // ----------------------------------------------------------------------
   logic acc;
   logic [7:0] a8;
   logic [15:0] wd;
   logic wr_status;
   logic wr_core;
   logic wr_soft;
   logic wr_hard;

   assign acc = HSEL_I && HREADY_I && HTRANS_I[1] && CE_I;
   assign a8 = HADDR_I[7:0];
   assign wd = HWDATA_I[15:0];
   assign wr_status = wr_pend_reg && (wr_addr_reg == CPT_OFF_STATUS);
   assign wr_core = wr_pend_reg && (wr_addr_reg == CPT_OFF_CORE);
   assign wr_soft = wr_pend_reg && (wr_addr_reg == CPT_OFF_SOFT);
   assign wr_hard = wr_pend_reg && (wr_addr_reg == CPT_OFF_HARD);
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else if (CE_I) begin
         wr_pend_reg <= acc && HWRITE_I;
         wr_addr_reg <= a8;
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         rdata_reg <= 32'h0000_0000;
      end else if (CE_I && acc && !HWRITE_I) begin
         case (a8)
            CPT_OFF_STATUS: rdata_reg <= {24'h0, prio_low_reg, 5'h00};
            CPT_OFF_CORE: rdata_reg <= {16'h0, var_lat_reg, 11'h000,
               prio_top_reg, 3'h0};
            CPT_OFF_SOFT: rdata_reg <= {23'h0, nvm_flag_reg, 3'h0,
               loop_flag_reg, 3'h0, pll_flag_reg};
            CPT_OFF_HARD: rdata_reg <= {31'h0, sw_hard_flag_reg};
            CPT_OFF_INTCTL: rdata_reg <= {16'h0, nesting_disable_reg, 15'h0};
            CPT_OFF_IRQ_STAT: rdata_reg <= {28'h0, irq_stat_reg};
            CPT_OFF_IRQ_MASK: rdata_reg <= {28'h0, irq_mask_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end
   assign HRDATA_O = rdata_reg;

   // ----------------------------------------------------------------------
   // Priority level and core control
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         nesting_disable_reg <= 1'b0;
         var_lat_reg <= 1'b0;
      end else if (CE_I) begin
         if (wr_pend_reg && wr_addr_reg == CPT_OFF_INTCTL) begin
            nesting_disable_reg <= wd[CPT_NEST_BIT];
         end
         if (wr_core) begin
            var_lat_reg <= wd[CPT_VAR_BIT];
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         prio_low_reg <= CPT_PRIO_RST;
         prio_top_reg <= 1'b0;
      end else if (CE_I) begin
         if (PRIO_LOAD_I) begin
            prio_low_reg <= PRIO_LEVEL_I[2:0];
            prio_top_reg <= PRIO_LEVEL_I[3];
         end else begin
            if (wr_status && !nesting_disable_reg) begin
               prio_low_reg <= wd[CPT_PRIO_MSB:CPT_PRIO_LSB];
            end
            if (wr_core && !wd[CPT_TOP_BIT]) begin
               prio_top_reg <= 1'b0;
            end
         end
      end
   end

   assign CORE_O = {prio_top_reg, prio_low_reg,
      prio_top_reg || (prio_low_reg == CPT_PRIO_MAX),
      var_lat_reg};

   // ----------------------------------------------------------------------
   // Trap flags: set wins over software clear
   // ----------------------------------------------------------------------
   assign evt = {TRAP_EVT_I.sw_hard, TRAP_EVT_I.pll, TRAP_EVT_I.loop,
      TRAP_EVT_I.nvm};

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         nvm_flag_reg <= 1'b0;
         loop_flag_reg <= 1'b0;
         pll_flag_reg <= 1'b0;
         sw_hard_flag_reg <= 1'b0;
      end else if (CE_I) begin
         nvm_flag_reg <= evt[0] ||
            (nvm_flag_reg && !(wr_soft && !wd[CPT_NVM_BIT]));
         loop_flag_reg <= evt[1] ||
            (loop_flag_reg && !(wr_soft && !wd[CPT_LOOP_BIT]));
         pll_flag_reg <= evt[2] ||
            (pll_flag_reg && !(wr_soft && !wd[CPT_PLL_BIT]));
         sw_hard_flag_reg <= evt[3] ||
            (sw_hard_flag_reg && !(wr_hard && !wd[CPT_HARD_BIT]));
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt status (write one to clear) and mask
   // ----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < CPT_NUM_EVT; gi++) begin : g_irq
         always_ff @(posedge CLK_I or posedge RESET_I) begin
            if (RESET_I) begin
               irq_stat_reg[gi] <= 1'b0;
            end else if (CE_I) begin
               if (evt[gi]) begin
                  irq_stat_reg[gi] <= 1'b1;
               end else if (wr_pend_reg && wr_addr_reg == CPT_OFF_IRQ_STAT &&
                  wd[gi]) begin
                  irq_stat_reg[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         irq_mask_reg <= CPT_EVT_RST;
      end else if (CE_I && wr_pend_reg && wr_addr_reg == CPT_OFF_IRQ_MASK) begin
         irq_mask_reg <= wd[3:0];
      end
   end

   assign IRQ_O = |(irq_stat_reg & irq_mask_reg);

   // ----------------------------------------------------------------------
   // Checks: priority level
   // ----------------------------------------------------------------------
   chk_level_load: assert property (
      CE_I && PRIO_LOAD_I |=> CORE_O.level == $past(PRIO_LEVEL_I))
      else $error("level not loaded from core");
   chk_top_blocks: assert property (
      CORE_O.level[3] |-> CORE_O.user_block)
      else $error("user interrupts not blocked at high level");
   chk_seven_blocks: assert property (
      CORE_O.level[2:0] == CPT_PRIO_MAX |-> CORE_O.user_block)
      else $error("level 7 does not block");
   chk_low_open: assert property (
      CORE_O.level < 4'h7 |-> !CORE_O.user_block)
      else $error("user interrupts blocked below level 7");
   chk_field_write: assert property (
      CE_I && wr_status && !nesting_disable_reg && !PRIO_LOAD_I
      |=> prio_low_reg == $past(wd[CPT_PRIO_MSB:CPT_PRIO_LSB]))
      else $error("priority field not written");
   chk_nest_locks: assert property (
      CE_I && wr_status && nesting_disable_reg && !PRIO_LOAD_I
      |=> $stable(prio_low_reg))
      else $error("field written while nesting disabled");

   // ----------------------------------------------------------------------
   // Checks: core control
   // ----------------------------------------------------------------------
   chk_top_no_set: assert property (
      !prio_top_reg && !PRIO_LOAD_I |=> !prio_top_reg)
      else $error("top bit set without core load");
   chk_top_clear: assert property (
      CE_I && wr_core && !wd[CPT_TOP_BIT] && !PRIO_LOAD_I
      |=> !prio_top_reg)
      else $error("top bit not cleared by software");
   chk_var_write: assert property (
      CE_I && wr_core |=> var_lat_reg == $past(wd[CPT_VAR_BIT]))
      else $error("latency select not written");
   chk_var_hold: assert property (
      !(CE_I && wr_core) |=> $stable(var_lat_reg))
      else $error("latency select changed without write");

   // ----------------------------------------------------------------------
   // Checks: trap flags
   // ----------------------------------------------------------------------
   chk_nvm_set: assert property (
      CE_I && evt[0] |=> nvm_flag_reg)
      else $error("nvm flag not set");
   chk_loop_set: assert property (
      CE_I && evt[1] |=> loop_flag_reg)
      else $error("loop flag not set");
   chk_pll_set: assert property (
      CE_I && evt[2] |=> pll_flag_reg)
      else $error("pll flag not set");
   chk_hard_set: assert property (
      CE_I && evt[3] |=> sw_hard_flag_reg)
      else $error("hard trap flag not set");
   chk_flag_sticky: assert property (
      pll_flag_reg && !wr_soft |=> pll_flag_reg)
      else $error("flag dropped without write");
   chk_nvm_sticky: assert property (
      nvm_flag_reg && !wr_soft |=> nvm_flag_reg)
      else $error("nvm flag dropped without write");
   chk_loop_sticky: assert property (
      loop_flag_reg && !wr_soft |=> loop_flag_reg)
      else $error("loop flag dropped without write");
   chk_hard_sticky: assert property (
      sw_hard_flag_reg && !wr_hard |=> sw_hard_flag_reg)
      else $error("hard trap flag dropped without write");
   chk_flag_clear: assert property (
      CE_I && wr_soft && !wd[CPT_PLL_BIT] && !evt[2] |=> !pll_flag_reg)
      else $error("pll flag not cleared by write of zero");
   chk_hard_clear: assert property (
      CE_I && wr_hard && !wd[CPT_HARD_BIT] && !evt[3]
      |=> !sw_hard_flag_reg)
      else $error("hard trap flag not cleared by write of zero");

   // ----------------------------------------------------------------------
   // Checks: read data
   // ----------------------------------------------------------------------
   chk_soft_zeros: assert property (
      CE_I && acc && !HWRITE_I && a8 == CPT_OFF_SOFT
      |=> HRDATA_O[15:9] == 7'h00 && HRDATA_O[7:5] == 3'h0
         && HRDATA_O[3:1] == 3'h0)
      else $error("unused trap status bits not zero");
   chk_hard_zeros: assert property (
      CE_I && acc && !HWRITE_I && a8 == CPT_OFF_HARD
      |=> HRDATA_O[15:1] == 15'h0000)
      else $error("unused hard trap bits not zero");

   // ----------------------------------------------------------------------
   // Coverage
   // ----------------------------------------------------------------------
   cov_nest_write: cover property (wr_status && nesting_disable_reg);
   cov_high_level: cover property (prio_top_reg);
   cov_set_clear: cover property (evt[0] && wr_soft && !wd[CPT_NVM_BIT]);
   cov_irq: cover property (IRQ_O);
   cov_level_load: cover property (CE_I && PRIO_LOAD_I);
endmodule

/* File: src/cpt_pkg.sv */
// Package: register map, field positions and types of the priority/trap block
package cpt_pkg;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] CPT_OFF_STATUS = 8'h00;
   localparam logic [7:0] CPT_OFF_CORE = 8'h04;
   localparam logic [7:0] CPT_OFF_SOFT = 8'h08;
   localparam logic [7:0] CPT_OFF_HARD = 8'h0c;
   localparam logic [7:0] CPT_OFF_INTCTL = 8'h10;
   localparam logic [7:0] CPT_OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] CPT_OFF_IRQ_MASK = 8'h18;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int CPT_PRIO_LSB = 5;
   localparam int CPT_PRIO_MSB = 7;
   localparam int CPT_TOP_BIT = 3;
   localparam int CPT_VAR_BIT = 15;
   localparam int CPT_NVM_BIT = 8;
   localparam int CPT_LOOP_BIT = 4;
   localparam int CPT_PLL_BIT = 0;
   localparam int CPT_HARD_BIT = 0;
   localparam int CPT_NEST_BIT = 15;
   localparam int CPT_NUM_EVT = 4;

   // ----------------------------------------------------------------------
   // Reset values and constants
   // ----------------------------------------------------------------------
   localparam logic [2:0] CPT_PRIO_RST = 3'h0;
   localparam logic [2:0] CPT_PRIO_MAX = 3'h7;
   localparam logic [15:0] CPT_REG_RST = 16'h0000;
   localparam logic [3:0] CPT_EVT_RST = 4'h0;
   localparam logic [1:0] CPT_HTRANS_NONSEQ = 2'h2;

   // Trap event group: bit 0 nvm, 1 loop, 2 pll, 3 sw hard trap
   typedef struct packed {
      logic sw_hard;
      logic pll;
      logic loop;
      logic nvm;
   } cpt_evt_t;

   // Core-facing status outputs
   typedef struct packed {
      logic [3:0] level;
      logic user_block;
      logic var_latency;
   } cpt_core_t;

endpackage

/* File: verification/cpt_core_model.sv */
// Core-side model: trap sources and priority level loads
`timescale 1ns/1ps
module cpt_core_model (
   input wire logic clk_i,
   output cpt_pkg::cpt_evt_t evt_o,
   output logic load_o,
   output logic [3:0] level_o
);
   import cpt_pkg::*;
   initial begin
      evt_o = CPT_EVT_RST;
      load_o = 1'b0;
      level_o = 4'h0;
   end
   // One-cycle trap pulses; flags stay set until software clears them
   task automatic fire(input logic [3:0] e);
      @(posedge clk_i);
      evt_o <= e;
      @(posedge clk_i);
      evt_o <= CPT_EVT_RST;
   endtask
   // Level load; level lines show the inverse once released
   task automatic load(input logic [3:0] l);
      @(posedge clk_i);
      level_o <= l;
      load_o <= 1'b1;
      @(posedge clk_i);
      load_o <= 1'b0;
      level_o <= ~l;
   endtask
endmodule

/* File: verification/cpu_priority_trap_status_tb_top.sv */
// Testbench: register and trap checks of the priority/trap block
`timescale 1ns/1ps
module cpu_priority_trap_status_tb_top;
   import cpt_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic irq;
   cpt_evt_t evt;
   logic load;
   logic [3:0] lvl;
   cpt_core_t core;
   int n_errors = 0;
   int n_tests = 0;
   logic [31:0] rd;

   cpt_core_model core_m (.clk_i(clk), .evt_o(evt), .load_o(load),
      .level_o(lvl));
   cpt_top DUT (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .TRAP_EVT_I(evt), .PRIO_LOAD_I(load), .PRIO_LEVEL_I(lvl),
      .CORE_O(core), .IRQ_O(irq));

   initial begin
      forever #2 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Bus tasks and checks
   // ---------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= CPT_HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rd, exp);
      check({31'h0, hresp}, 32'h0);
   endtask
   task automatic cchk(input logic [5:0] exp);
      #1;
      check({26'h0, core}, {26'h0, exp});
   endtask
   task automatic conclude;
      $display("tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      conclude();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rchk(CPT_OFF_STATUS, 32'h0);
      rchk(CPT_OFF_CORE, 32'h0);
      rchk(CPT_OFF_SOFT, 32'h0);
      rchk(CPT_OFF_HARD, 32'h0);
      rchk(8'h1c, 32'h0);
      wr(CPT_OFF_STATUS, 32'he0);
      rchk(CPT_OFF_STATUS, 32'he0);
      cchk({4'h7, 1'b1, 1'b0});
      wr(CPT_OFF_STATUS, 32'h20);
      cchk({4'h1, 1'b0, 1'b0});
      core_m.load(4'hb);
      cchk({4'hb, 1'b1, 1'b0});
      rchk(CPT_OFF_CORE, 32'h8);
      rchk(CPT_OFF_STATUS, 32'h60);
      wr(CPT_OFF_CORE, 32'h8);
      rchk(CPT_OFF_CORE, 32'h8);
      wr(CPT_OFF_CORE, 32'h8000);
      rchk(CPT_OFF_CORE, 32'h8000);
      cchk({4'h3, 1'b0, 1'b1});
      wr(CPT_OFF_CORE, 32'h0);
      rchk(CPT_OFF_CORE, 32'h0);
      wr(CPT_OFF_CORE, 32'h8);
      rchk(CPT_OFF_CORE, 32'h0);
      ce <= 1'b0;
      wr(CPT_OFF_STATUS, 32'h80);
      ce <= 1'b1;
      rchk(CPT_OFF_STATUS, 32'h60);
      wr(CPT_OFF_INTCTL, 32'h8000);
      wr(CPT_OFF_STATUS, 32'ha0);
      rchk(CPT_OFF_STATUS, 32'h60);
      wr(CPT_OFF_INTCTL, 32'h0);
      wr(CPT_OFF_STATUS, 32'ha0);
      rchk(CPT_OFF_STATUS, 32'ha0);
      wr(CPT_OFF_IRQ_MASK, 32'h0);
      core_m.fire(4'hf);
      #1;
      check({31'h0, irq}, 32'h0);
      rchk(CPT_OFF_SOFT, 32'h0111);
      rchk(CPT_OFF_HARD, 32'h1);
      rchk(CPT_OFF_IRQ_STAT, 32'hf);
      wr(CPT_OFF_IRQ_MASK, 32'h4);
      #1;
      check({31'h0, irq}, 32'h1);
      wr(CPT_OFF_SOFT, 32'hffff);
      rchk(CPT_OFF_SOFT, 32'h0111);
      wr(CPT_OFF_SOFT, 32'h0110);
      rchk(CPT_OFF_SOFT, 32'h0110);
      wr(CPT_OFF_IRQ_STAT, 32'h4);
      #1;
      check({31'h0, irq}, 32'h0);
      rchk(CPT_OFF_IRQ_STAT, 32'hb);
      wr(CPT_OFF_HARD, 32'h0);
      rchk(CPT_OFF_HARD, 32'h0);
      conclude();
   end
endmodule
